/* hw/cont_defines.vh */
// constants for the continuous reporting block
`ifndef CONT_DEFINES_VH
`define CONT_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ      250000
`define STROBE_MS    5
`define TICK_MS      10
`define BAUD_DIV     16'h65B9

// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_MODE       8'h00
`define A_IVL        8'h04
`define A_DIR        8'h08
`define A_ADDR       8'h0C
`define A_STAT       8'h10
`define A_SNAP       8'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MODE     2'h0
`define RST_IVL      24'h000000
`define RST_DIR      16'h0000
`define RST_ADDR     8'h31

// ----------------------------------------
// mode codes
// ----------------------------------------
`define M_OFF        2'h0
`define M_TIMER      2'h1
`define M_EDGE       2'h2
`define M_CHANGE     2'h3

// ----------------------------------------
// characters
// ----------------------------------------
`define C_STAR       8'h2A
`define C_DOLLAR     8'h24
`define C_HASH       8'h23
`define C_CR         8'h0D
`define C_C          8'h43
`define C_M          8'h4D
`define C_D          8'h44
`define C_T          8'h54
`define C_E          8'h45
`define C_I          8'h49

`endif

/* hw/serial_rx.v */
// serial byte receiver, 8 data bits, one stop bit
`timescale 1ns/1ps
`include "cont_defines.vh"

module serial_rx #(
    parameter [15:0] DIV = `BAUD_DIV
) (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       rxd,
    output reg        rx_valid,
    output reg  [7:0] rx_byte
);
    localparam [15:0] HALF   = {1'b0, DIV[15:1]};
    localparam [15:0] DIV_M1 = DIV - 16'h0001;

    reg        s1_q;
    reg        s2_q;
    reg        busy_q;
    reg [15:0] cnt_q;
    reg [3:0]  bit_q;
    reg [7:0]  sh_q;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            busy_q   <= 1'b0;
            cnt_q    <= 16'h0000;
            bit_q    <= 4'h0;
            sh_q     <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            s1_q     <= rxd;
            s2_q     <= s1_q;
            rx_valid <= 1'b0;
            if (!busy_q) begin
                if (!s2_q) begin
                    busy_q <= 1'b1;
                    cnt_q  <= HALF;
                    bit_q  <= 4'h0;
                end
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                cnt_q <= DIV_M1;
                bit_q <= bit_q + 4'h1;
                // a start bit that is gone at mid-bit was a glitch
                if (bit_q == 4'h0) begin
                    if (s2_q)
                        busy_q <= 1'b0;
                end else if (bit_q == 4'h9) begin
                    busy_q <= 1'b0;
                    if (s2_q) begin
                        rx_valid <= 1'b1;
                        rx_byte  <= sh_q;
                    end
                end else begin
                    sh_q <= {s2_q, sh_q[7:1]};
                end
            end
        end
    end
endmodule

/* hw/serial_tx.v */
// serial byte transmitter with line driver enable
`timescale 1ns/1ps
`include "cont_defines.vh"

module serial_tx #(
    parameter [15:0] DIV = `BAUD_DIV
) (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       tx_go,
    input  wire [7:0] tx_byte,
    output reg        tx_busy,
    output reg        txd,
    output reg        line_oe
);
    localparam [15:0] DIV_M1 = DIV - 16'h0001;

    reg [9:0]  sh_q;
    reg [3:0]  n_q;
    reg [15:0] cnt_q;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sh_q    <= 10'h3FF;
            n_q     <= 4'h0;
            cnt_q   <= 16'h0000;
            tx_busy <= 1'b0;
            txd     <= 1'b1;
            line_oe <= 1'b0;
        end else if (!tx_busy) begin
            if (tx_go) begin
                sh_q    <= {1'b1, tx_byte, 1'b0};
                n_q     <= 4'hA;
                cnt_q   <= 16'h0000;
                tx_busy <= 1'b1;
                line_oe <= 1'b1;
            end
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end else if (n_q == 4'h0) begin
            // stop bit has had its full time; release the shared line
            tx_busy <= 1'b0;
            line_oe <= 1'b0;
        end else begin
            txd   <= sh_q[0];
            sh_q  <= {1'b1, sh_q[9:1]};
            n_q   <= n_q - 4'h1;
            cnt_q <= DIV_M1;
        end
    end
endmodule

/* hw/continuous_report_modes.v */
// continuous reporting control: mode registers, command watch, report framing
`timescale 1ns/1ps
`include "cont_defines.vh"

// Notes on behaviour
// R1: long disable leaves mode, echoes with checksum
// R2: host repeats long disable until echo right
// R3: periodic module strobes after each report
// R4: chain is one periodic, up to 123 edge
// R5: report carries address first, ends with CR
// R6: periodic interval covers whole chain's reports
// R7: edge mode waits interval, zero means immediate
// R8: disabled answers polls; periodic enable resumes
// R9: change mode reports all lines on input change
// R10: change mode scans, resumes after report sent
// R11: nonzero interval is dead time after report
// R12: disabled change mode answers ordinary commands
// R13: change enable command re-enters change mode
// R14: shared change bus uses checksum and parity; the serial frames here are 8N1 with no parity bit
// R15: host treats bus activity as change
// R16: shared change bus uses highest baud rate
// R17: after report, 5 ms low strobe pulse
// R18: edge mode starts on rising trigger edge
// R19: command start pauses output, checks address
// R20: checksum is low byte sum, two hex
module continuous_report_modes #(
    parameter [15:0] BAUD_DIV   = `BAUD_DIV,
    parameter [31:0] STROBE_CYC = `STROBE_MS * `CLK_KHZ,
    parameter [31:0] TICK_CYC   = `TICK_MS * `CLK_KHZ
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rxd,
    output wire        txd,
    output wire        tx_oe,
    input  wire [15:0] io_lines,
    input  wire        edge_trigger_pin,
    input  wire        strobe_in,
    output reg         strobe_o,
    output reg         strobe_oe
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] S_IDLE   = 3'd0;
    localparam [2:0] S_WAIT   = 3'd1;
    localparam [2:0] S_SEND   = 3'd2;
    localparam [2:0] S_STROBE = 3'd3;
    localparam [2:0] S_DEAD   = 3'd4;
    localparam [1:0] P_IDLE   = 2'd0;
    localparam [1:0] P_ADDR   = 2'd1;
    localparam [1:0] P_CMD    = 2'd2;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [1:0]  mode_q;
    reg [23:0] ivl_q;
    reg [15:0] dir_q;
    reg [7:0]  addr_q;
    reg [15:0] ln1_q;
    reg [15:0] ln2_q;
    reg        ev1_q;
    reg        ev2_q;
    reg        ev3_q;
    reg        sb1_q;
    reg        sb2_q;
    reg [2:0]  st_q;
    reg [15:0] rep_q;
    reg        echo_q;
    reg [3:0]  idx_q;
    reg [7:0]  cks_q;
    reg        go_q;
    reg [7:0]  byte_q;
    reg [23:0] left_q;
    reg [31:0] pre_q;
    reg        edge_seen_q;
    reg [1:0]  ps_q;
    reg        long_q;
    reg        pause_q;
    reg        echo_req_q;
    reg [2:0]  n_q;
    reg [7:0]  c0_q;
    reg [7:0]  c1_q;
    reg [7:0]  c2_q;
    reg [7:0]  ch;
    reg [31:0] rd;
    reg        hit;
    wire       rx_valid;
    wire [7:0] rx_byte;
    wire       tx_busy;
    wire [3:0] plen = echo_q ? 4'h5 : 4'h8;
    wire       apb_wr = psel & penable & pwrite & pready;
    wire       rise = ev2_q & ~ev3_q;
    wire       ivl_done = (left_q == 24'h000000);
    wire       changed = |((ln2_q ^ rep_q) & ~dir_q);
    wire       start_ch = (rx_byte == `C_DOLLAR) || (rx_byte == `C_HASH);
    wire       take_echo = (st_q == S_IDLE) && echo_req_q;
    wire       take_edge;

    function [7:0] hexc;
        input [3:0] n;
        hexc = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
    endfunction

    serial_rx #(.DIV(BAUD_DIV)) u_rx (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .rxd      (rxd),
        .rx_valid (rx_valid),
        .rx_byte  (rx_byte)
    );

    serial_tx #(.DIV(BAUD_DIV)) u_tx (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .tx_go    (go_q),
        .tx_byte  (byte_q),
        .tx_busy  (tx_busy),
        .txd      (txd),
        .line_oe  (tx_oe)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ln1_q <= 16'h0000;
            ln2_q <= 16'h0000;
            ev1_q <= 1'b0;
            ev2_q <= 1'b0;
            ev3_q <= 1'b0;
            sb1_q <= 1'b1;
            sb2_q <= 1'b1;
        end else begin
            ln1_q <= io_lines;
            ln2_q <= ln1_q;
            ev1_q <= edge_trigger_pin;
            ev2_q <= ev1_q;
            ev3_q <= ev2_q;
            sb1_q <= strobe_in;
            sb2_q <= sb1_q;
        end
    end

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    always @* begin
        hit = 1'b1;
        rd  = 32'h00000000;
        case (paddr)
            `A_MODE: rd = {30'h0, mode_q};
            `A_IVL:  rd = {8'h00, ivl_q};
            `A_DIR:  rd = {16'h0000, dir_q};
            `A_ADDR: rd = {24'h000000, addr_q};
            `A_STAT: rd = {26'h0, edge_seen_q, sb2_q, pause_q, st_q};
            `A_SNAP: rd = {16'h0000, rep_q};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            ivl_q   <= `RST_IVL;
            dir_q   <= `RST_DIR;
            addr_q  <= `RST_ADDR;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready)
                prdata <= hit ? rd : 32'h00000000;
            if (apb_wr && paddr == `A_IVL)
                ivl_q <= pwdata[23:0];
            if (apb_wr && paddr == `A_DIR)
                dir_q <= pwdata[15:0];
            if (apb_wr && paddr == `A_ADDR)
                addr_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // command watch on the shared bus
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_q     <= `RST_MODE;
            ps_q       <= P_IDLE;
            long_q     <= 1'b0;
            pause_q    <= 1'b0;
            echo_req_q <= 1'b0;
            n_q        <= 3'h0;
            c0_q       <= 8'h00;
            c1_q       <= 8'h00;
            c2_q       <= 8'h00;
        end else begin
            if (take_echo)
                echo_req_q <= 1'b0;
            if (apb_wr && paddr == `A_MODE)
                mode_q <= pwdata[1:0];
            if (rx_valid) begin
                case (ps_q)
                    P_IDLE: begin
                        if (start_ch) begin
                            pause_q <= 1'b1;                        // [R19]
                            long_q  <= (rx_byte == `C_HASH);
                            ps_q    <= P_ADDR;
                            n_q     <= 3'h0;
                        end
                    end
                    P_ADDR: begin
                        if (rx_byte == addr_q) begin
                            ps_q <= P_CMD;
                        end else begin
                            pause_q <= 1'b0;                        // [R19]
                            ps_q    <= P_IDLE;
                        end
                    end
                    P_CMD: begin
                        if (rx_byte == `C_CR) begin
                            pause_q <= 1'b0;
                            ps_q    <= P_IDLE;
                            // other polled commands pass to the general set
                            if (n_q == 3'h3 && c0_q == `C_C && c1_q == `C_M) begin
                                case (c2_q)
                                    `C_D: begin
                                        mode_q <= `M_OFF;           // [R8] [R12]
                                        if (long_q)
                                            echo_req_q <= 1'b1;     // [R1]
                                    end
                                    `C_T: mode_q <= `M_TIMER;       // [R8]
                                    `C_E: mode_q <= `M_EDGE;
                                    `C_C: mode_q <= `M_CHANGE;      // [R13]
                                    default: mode_q <= mode_q;
                                endcase
                            end
                        end else if (n_q < 3'h4) begin
                            n_q <= n_q + 3'h1;
                            if (n_q == 3'h0)
                                c0_q <= rx_byte;
                            if (n_q == 3'h1)
                                c1_q <= rx_byte;
                            if (n_q == 3'h2)
                                c2_q <= rx_byte;
                        end
                    end
                    default: ps_q <= P_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // frame characters
    // ----------------------------------------
    always @* begin
        ch = `C_CR;                                                 // [R5]
        if (idx_q < plen) begin
            case (idx_q)
                4'h0: ch = `C_STAR;
                4'h1: ch = addr_q;                                  // [R5]
                4'h2: ch = echo_q ? `C_C : `C_D;
                4'h3: ch = echo_q ? `C_M : `C_I;
                4'h4: ch = echo_q ? `C_D : hexc(rep_q[15:12]);
                4'h5: ch = hexc(rep_q[11:8]);
                4'h6: ch = hexc(rep_q[7:4]);
                default: ch = hexc(rep_q[3:0]);
            endcase
        end else if (idx_q == plen) begin
            ch = hexc(cks_q[7:4]);                                  // [R20]
        end else if (idx_q == plen + 4'h1) begin
            ch = hexc(cks_q[3:0]);                                  // [R20]
        end
    end

    // ----------------------------------------
    // reporting sequencer
    // ----------------------------------------
    assign take_edge = (st_q == S_IDLE) && !echo_req_q && !pause_q
                       && mode_q == `M_EDGE && edge_seen_q;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q        <= S_IDLE;
            rep_q       <= 16'h0000;
            echo_q      <= 1'b0;
            idx_q       <= 4'h0;
            cks_q       <= 8'h00;
            go_q        <= 1'b0;
            byte_q      <= 8'h00;
            left_q      <= 24'h000000;
            pre_q       <= 32'h00000000;
            edge_seen_q <= 1'b0;
            strobe_o    <= 1'b1;
            strobe_oe   <= 1'b0;
        end else begin
            // a trigger arriving while one is consumed is kept
            edge_seen_q <= (mode_q == `M_EDGE)
                           & (rise | (edge_seen_q & ~take_edge));  // [R18]
            if (st_q == S_WAIT || st_q == S_DEAD) begin
                if (!ivl_done) begin
                    if (pre_q == TICK_CYC - 32'h1) begin
                        pre_q  <= 32'h00000000;
                        left_q <= left_q - 24'h000001;
                    end else begin
                        pre_q <= pre_q + 32'h1;
                    end
                end
            end else begin
                pre_q  <= 32'h00000000;
                left_q <= ivl_q;
            end
            case (st_q)
                S_IDLE: begin
                    idx_q <= 4'h0;
                    cks_q <= 8'h00;
                    if (mode_q != `M_CHANGE)
                        rep_q <= ln2_q;
                    if (take_echo) begin
                        echo_q <= 1'b1;
                        st_q   <= S_SEND;                           // [R1]
                    end else if (!pause_q) begin
                        echo_q <= 1'b0;
                        if (mode_q == `M_TIMER)
                            st_q <= S_WAIT;
                        else if (take_edge)
                            st_q <= S_WAIT;                         // [R7]
                        else if (mode_q == `M_CHANGE && changed) begin
                            rep_q <= ln2_q;                         // [R9]
                            st_q  <= S_SEND;
                        end
                    end
                end
                S_WAIT: begin
                    if (mode_q != `M_TIMER && mode_q != `M_EDGE)
                        st_q <= S_IDLE;
                    else if (ivl_done) begin
                        rep_q <= ln2_q;                             // [R7]
                        st_q  <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (go_q) begin
                        go_q <= 1'b0;
                    end else if (!tx_busy) begin
                        if (idx_q == plen + 4'h3) begin
                            st_q <= echo_q ? S_IDLE : S_STROBE;     // [R10]
                        end else if (echo_q || !pause_q) begin
                            // a report holds between characters while a command is on the bus
                            go_q   <= 1'b1;                         // [R19]
                            byte_q <= ch;
                            idx_q  <= idx_q + 4'h1;
                            if (idx_q < plen)
                                cks_q <= cks_q + ch;                // [R20]
                        end
                    end
                end
                S_STROBE: begin
                    strobe_oe <= 1'b1;                              // [R17]
                    strobe_o  <= 1'b0;
                    if (pre_q == STROBE_CYC) begin
                        strobe_oe <= 1'b0;                          // [R17]
                        strobe_o  <= 1'b1;
                        pre_q     <= 32'h00000000;
                        if (mode_q == `M_TIMER)
                            st_q <= S_WAIT;                         // [R3]
                        else if (mode_q == `M_CHANGE)
                            st_q <= S_DEAD;                         // [R11]
                        else
                            st_q <= S_IDLE;
                    end else begin
                        pre_q <= pre_q + 32'h1;
                    end
                end
                S_DEAD: begin
                    // scanning is suspended until the dead time runs out
                    if (mode_q != `M_CHANGE || ivl_done)
                        st_q <= S_IDLE;                             // [R11] [R10]
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* sim/cont_props.sv */
// checker for the continuous reporting block ports
`timescale 1ns/1ps
module cont_props #(
    parameter [31:0] STROBE_CYC = 32'h14
) (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire        pready,
    input wire        pslverr,
    input wire        txd,
    input wire        tx_oe,
    input wire        strobe_o,
    input wire        strobe_oe
);
    // ----
    // helpers
    // ----
    logic [31:0] s_cnt;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            s_cnt <= 32'h0;
        else
            s_cnt <= strobe_oe ? s_cnt + 32'h1 : 32'h0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_access;
        psel && $rose(penable);
    endsequence
    sequence s_start;
        $fell(txd);
    endsequence
    // ----
    // assertions
    // ----
    a_ready_wait: assert property (s_access |=> pready)
        else $error("ready not one cycle after enable");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_pair: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (pready && psel && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    a_strobe_low: assert property (strobe_oe |-> !strobe_o)
        else $error("strobe driven high");
    a_strobe_idle: assert property (!strobe_oe |-> strobe_o)
        else $error("strobe value low while released");
    // count checked at the fall, so a stuck pulse shows as a cap breach
    a_strobe_width: assert property ($fell(strobe_oe) |-> s_cnt == STROBE_CYC)
        else $error("strobe pulse width wrong");
    a_strobe_cap: assert property (s_cnt <= STROBE_CYC)
        else $error("strobe pulse too long");
    a_strobe_after: assert property ($rose(strobe_oe) |-> !tx_oe)
        else $error("strobe during transmission");
    a_tx_idle: assert property (!tx_oe |-> txd)
        else $error("line low while driver off");
    a_start_bit: assert property (s_start |-> (!txd)[*8])
        else $error("start bit too short");
endmodule

bind continuous_report_modes cont_props #(.STROBE_CYC(STROBE_CYC)) u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .txd(txd),
    .tx_oe(tx_oe), .strobe_o(strobe_o), .strobe_oe(strobe_oe));

/* sim/serial_host.sv */
// host on the shared serial bus: sends commands, logs characters seen
`timescale 1ns/1ps
module serial_host #(
    parameter int DIV = 8
) (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got[$];
    initial rxd = 1'b1;
    // 8N1, idle high; the caller sends a disable once and then checks its echo
    task automatic send(input string s);
        logic [9:0] f;
        for (int i = 0; i < s.len(); i++) begin
            f = {1'b1, s[i], 1'b0};
            for (int b = 0; b < 10; b++) begin
                rxd <= f[b];
                repeat (DIV) @(posedge clk_sys);
            end
        end
    endtask
    // every start bit is logged as activity, garbled or not
    always begin
        logic [7:0] v;
        @(negedge txd);
        repeat (DIV / 2) @(posedge clk_sys);
        for (int b = 0; b < 8; b++) begin
            repeat (DIV) @(posedge clk_sys);
            v[b] = txd;
        end
        got.push_back(v);
        repeat (DIV) @(posedge clk_sys);
    end
endmodule

/* sim/testbench.sv */
// self-checking bench for the continuous reporting block
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, rst_b, psel, penable, pwrite, rxd, txd, tx_oe, er;
    logic        edge_trigger_pin, pready, pslverr, strobe_o, strobe_oe;
    logic [7:0]  paddr;
    logic [15:0] io_lines;
    logic [31:0] pwdata, prdata, rd;
    int          n_errors = 0, n_checks = 0, cyc = 0;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
    row_t rows[5] = '{'{8'h04, 32'hFF000000, 32'h0, 1'b0},
                      '{8'h08, 32'hFFFF00FF, 32'h000000FF, 1'b0},
                      '{8'h0C, 32'hFFFFFF31, 32'h00000031, 1'b0},
                      '{8'h00, 32'hFFFFFFFC, 32'h0, 1'b0},
                      '{8'h18, 32'h12345678, 32'h0, 1'b1}};

    continuous_report_modes #(.BAUD_DIV(16'h0008), .STROBE_CYC(32'h14),
        .TICK_CYC(32'hA)) u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_oe(tx_oe),
        .io_lines(io_lines), .edge_trigger_pin(edge_trigger_pin),
        .strobe_in(strobe_oe ? strobe_o : 1'b1), .strobe_o(strobe_o),
        .strobe_oe(strobe_oe));
    serial_host #(.DIV(8)) u_host (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

    // ----
    // tasks
    // ----
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one edge first, so a release and the next setup never share a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? 8'h30 + n : 8'h37 + n;
    endfunction
    task automatic expect_frame(input string s);
        logic [7:0] c, e;
        c = 8'h00;
        for (int i = 0; i < s.len() + 3; i++) begin
            e = i < s.len() ? s[i] : i == s.len() ? hx(c[7:4]) :
                i == s.len() + 1 ? hx(c[3:0]) : 8'h0D;
            if (i < s.len())
                c += s[i];
            while (u_host.got.size() == 0) @(posedge clk_sys);
            chk("reply char", {24'h0, u_host.got.pop_front()}, {24'h0, e});
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    // ----
    // sequence
    // ----
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        io_lines = 16'h1235;
        edge_trigger_pin = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        apb(0, 8'h0C, 32'h0);
        chk("address reset", rd, 32'h00000031);
        apb(0, 8'h00, 32'h0);
        chk("mode reset", rd, 32'h0);
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].w);
            apb(0, rows[i].a, 32'h0);
            chk("register", rd, rows[i].r);
            chk("error flag", {31'h0, er}, {31'h0, rows[i].e});
        end
        $display("register test done");
        apb(1, 8'h00, 32'h00000002);
        edge_trigger_pin <= 1'b1;
        expect_frame("*1DI1235");
        while (strobe_oe !== 1'b1) @(posedge clk_sys);
        chk("strobe value", {31'h0, strobe_o}, 32'h0);
        edge_trigger_pin <= 1'b0;
        $display("edge test done");
        u_host.send("#1CMD\r");
        expect_frame("*1CMD");
        apb(0, 8'h00, 32'h0);
        chk("mode after disable", rd, 32'h0);
        $display("disable test done");
        u_host.send("$1CMC\r");
        apb(0, 8'h00, 32'h0);
        chk("change mode", rd, 32'h00000003);
        io_lines <= 16'h12CA;
        repeat (200) @(posedge clk_sys);
        io_lines <= 16'hA5CA;
        expect_frame("*1DIA5CA");
        $display("change test done");
        u_host.send("$1CMT\r");
        apb(0, 8'h00, 32'h0);
        chk("timer mode", rd, 32'h00000001);
        expect_frame("*1DIA5CA");
        $display("timer enable test done");
        close_out();
    end
endmodule
